/* File: include/rxpf_regs.vh */
// receive filter/status block: offsets, bit positions, masks, reset values
// assumes: included by bare name from the design files under verilog/
`ifndef RXPF_REGS_VH
`define RXPF_REGS_VH

// ==========================================================================
// register map (printed offset is an index, byte address is index * 4)
// ==========================================================================
`define RXPF_RECEIVE_CONTROL_INDEX 6'h02
`define RXPF_APB_ADDR_W            8

// ==========================================================================
// receive_control bit positions
// ==========================================================================
`define RXPF_B_ACCEPT_ERRORED      15
`define RXPF_B_ACCEPT_SHORT        14
`define RXPF_B_ACCEPT_ALL_ONES     13
`define RXPF_B_ACCEPT_ANY_UNICAST  12
`define RXPF_B_ACCEPT_EVERY_GROUP  11
`define RXPF_B_LOOP_SELECT_HI      10
`define RXPF_B_LOOP_SELECT_LO      9
`define RXPF_B_GROUP_SEEN          8
`define RXPF_B_ALL_ONES_SEEN       7
`define RXPF_B_FINAL_FRAME         6
`define RXPF_B_CARRIER_SEEN        5
`define RXPF_B_COLLISION_SEEN      4
`define RXPF_B_CHECKSUM_FAULT      3
`define RXPF_B_ALIGN_FAULT         2
`define RXPF_B_LOOPED_FRAME        1
`define RXPF_B_CLEAN_FRAME         0

// ==========================================================================
// masks and reset values
// ==========================================================================
`define RXPF_CTRL_RESET            7'h00
`define RXPF_STAT_RESET            9'h000
`define RXPF_START_CLEAR_MASK      9'h1CF

// ==========================================================================
// loopback selector codes
// ==========================================================================
`define RXPF_LOOP_NONE             2'h0
`define RXPF_LOOP_MAC              2'h1
`define RXPF_LOOP_CODEC            2'h2
`define RXPF_LOOP_XCVR             2'h3

// ==========================================================================
// frame length
// ==========================================================================
`define RXPF_MIN_FRAME_BYTES       11'h040
`define RXPF_BYTE_CNT_MAX          11'h7FF

`endif

/* File: verilog/rxpf_dest_class.v */
// destination address classifier for the receive filter
// assumes: first octet in bits 47:40, its lsb is the group bit
`timescale 1ns/100ps

module rxpf_dest_class (
  input  wire [47:0] i_dest,      // destination address
  output wire        o_group,     // group (multicast) address
  output wire        o_all_ones,  // broadcast address
  output wire        o_unicast    // individual address
);

  // ========================================================================
  // classification
  // ========================================================================
  assign o_group    = i_dest[40];
  assign o_all_ones = &i_dest;
  assign o_unicast  = ~i_dest[40];

endmodule

/* File: verilog/rxpf_apb_slave.v */
// apb slave front end: decode, ready and error for one register word
// assumes: apb master on the same clock, one wait-free access phase
`timescale 1ns/100ps
`include "rxpf_regs.vh"

module rxpf_apb_slave (
  input  wire                        i_clock,    // system clock
  input  wire                        i_sys_rst,  // async reset, high
  input  wire                        i_psel,     // apb select
  input  wire                        i_penable,  // apb enable
  input  wire                        i_pwrite,   // apb direction
  input  wire [`RXPF_APB_ADDR_W-1:0] i_paddr,    // apb byte address
  output reg                         o_pready,   // apb ready
  output reg                         o_pslverr,  // apb error
  output wire                        o_setup,    // setup cycle
  output wire                        o_hit,      // address is mapped
  output wire                        o_wr_stb    // write takes effect
);

  wire setup_d;

  // ========================================================================
  // decode
  // ========================================================================
  assign setup_d  = i_psel & ~i_penable;
  assign o_setup  = setup_d;
  assign o_hit    = (i_paddr[7:2] == `RXPF_RECEIVE_CONTROL_INDEX) &
                    (i_paddr[1:0] == 2'h0);
  assign o_wr_stb = i_psel & i_penable & o_pready & i_pwrite & o_hit;

  // ========================================================================
  // ready in the first cycle of the access phase, error on unmapped address
  // ========================================================================
  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= setup_d;
      o_pslverr <= setup_d & ~o_hit;
    end
  end

endmodule

/* File: verilog/rxpf_top.v */
// receive acceptance filter and per-frame status register
// assumes: receive path strobes are on I_CLOCK, apb master on I_CLOCK
//
// Decided for this implementation: register access over APB.
`timescale 1ns/100ps
`include "rxpf_regs.vh"

module rxpf_top (
  input  wire                        I_CLOCK,              // system clock
  input  wire                        I_SYS_RST,            // async, high
  input  wire                        I_SOFT_RST,           // software reset
  input  wire                        I_PSEL,               // apb select
  input  wire                        I_PENABLE,            // apb enable
  input  wire                        I_PWRITE,             // apb direction
  input  wire [`RXPF_APB_ADDR_W-1:0] I_PADDR,              // apb address
  input  wire [31:0]                 I_PWDATA,             // apb write data
  input  wire [3:0]                  I_PSTRB,              // apb lanes
  output wire [31:0]                 O_PRDATA,             // apb read data
  output wire                        O_PREADY,             // apb ready
  output wire                        O_PSLVERR,            // apb error
  input  wire                        I_RX_FRAME_START,     // frame begins
  input  wire                        I_RX_DEST_VALID,      // dest present
  input  wire [47:0]                 I_RX_DEST,            // dest address
  input  wire                        I_RX_TABLE_MATCH,     // table hit
  input  wire                        I_RX_BYTE_STB,        // one byte in
  input  wire                        I_RX_COLLISION,       // collision now
  input  wire                        I_RX_CARRIER,         // carrier now
  input  wire                        I_RX_FRAME_END,       // frame ends
  input  wire                        I_RX_CHECKSUM_ERR,    // bad crc
  input  wire                        I_RX_ALIGN_ERR,       // odd bit count
  input  wire                        I_RX_FINAL_IN_BUFFER, // last in buffer
  input  wire                        I_DESC_ACK,           // status taken
  output wire [1:0]                  O_LOOP_MODE,          // loop select
  output wire                        O_FRAME_ACCEPT,       // frame kept
  output wire                        O_FRAME_REJECT,       // frame dropped
  output wire                        O_DESC_VALID,         // status pending
  output wire [15:0]                 O_DESC_STATUS         // descriptor word
);

  // ========================================================================
  // frame tracking states
  // ========================================================================
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_HEAD = 4'h2;
  localparam [3:0] ST_BODY = 4'h4;
  localparam [3:0] ST_END  = 4'h8;

  // ========================================================================
  // declarations
  // ========================================================================
  reg  [3:0]  state_q;
  reg  [3:0]  state_d;
  reg  [6:0]  ctrl_q;
  reg  [6:0]  ctrl_d;
  reg  [8:0]  stat_q;
  reg  [8:0]  stat_d;
  reg  [31:0] prdata_q;
  reg  [10:0] byte_cnt_q;
  reg  [10:0] byte_cnt_d;
  reg         group_q;
  reg         all_ones_q;
  reg         unicast_q;
  reg         table_q;
  reg         dest_seen_q;
  reg         coll_acc_q;
  reg         carr_acc_q;
  reg         crc_q;
  reg         align_q;
  reg         final_q;
  reg         accept_q;
  reg         reject_q;
  reg         desc_valid_q;
  reg  [15:0] desc_status_q;
  wire        apb_setup;
  wire        apb_hit;
  wire        apb_wr_stb;
  wire        apb_pready;
  wire        apb_pslverr;
  wire        dest_group;
  wire        dest_all_ones;
  wire        dest_unicast;
  wire        en_errored;
  wire        en_short;
  wire        en_all_ones;
  wire        en_any_unicast;
  wire        en_every_group;
  wire [1:0]  loop_sel;
  wire        is_short;
  wire        is_errored;
  wire        addr_ok;
  wire        err_ok;
  wire        len_ok;
  wire        frame_ok;
  wire        clean;
  wire [8:0]  frame_stat;
  wire        rx_start;
  wire        deciding;

  // ========================================================================
  // submodules
  // ========================================================================
  rxpf_apb_slave u_apb (
    .i_clock   (I_CLOCK),
    .i_sys_rst (I_SYS_RST),
    .i_psel    (I_PSEL),
    .i_penable (I_PENABLE),
    .i_pwrite  (I_PWRITE),
    .i_paddr   (I_PADDR),
    .o_pready  (apb_pready),
    .o_pslverr (apb_pslverr),
    .o_setup   (apb_setup),
    .o_hit     (apb_hit),
    .o_wr_stb  (apb_wr_stb)
  );

  rxpf_dest_class u_dest (
    .i_dest     (I_RX_DEST),
    .o_group    (dest_group),
    .o_all_ones (dest_all_ones),
    .o_unicast  (dest_unicast)
  );

  // ========================================================================
  // control field views
  // ========================================================================
  assign en_errored     = ctrl_q[`RXPF_B_ACCEPT_ERRORED - 9];
  assign en_short       = ctrl_q[`RXPF_B_ACCEPT_SHORT - 9];
  assign en_all_ones    = ctrl_q[`RXPF_B_ACCEPT_ALL_ONES - 9];
  assign en_any_unicast = ctrl_q[`RXPF_B_ACCEPT_ANY_UNICAST - 9];
  assign en_every_group = ctrl_q[`RXPF_B_ACCEPT_EVERY_GROUP - 9];
  assign loop_sel       = ctrl_q[1:0];

  // ========================================================================
  // acceptance decision for the frame being closed
  // ========================================================================
  assign rx_start   = I_RX_FRAME_START;
  assign deciding   = (state_q == ST_END);
  assign is_short   = (byte_cnt_q < `RXPF_MIN_FRAME_BYTES);
  assign is_errored = crc_q | coll_acc_q;

  // table hit plus each enabled extra filter
  assign addr_ok = dest_seen_q &
                   (table_q |
                    (en_all_ones & all_ones_q) |
                    (en_any_unicast & unicast_q) |
                    (en_every_group & group_q));
  assign err_ok   = ~is_errored | en_errored;
  assign len_ok   = ~is_short | en_short;
  assign frame_ok = addr_ok & err_ok & len_ok;

  // ========================================================================
  // per-frame status word
  // ========================================================================
  assign clean = ~crc_q & ~is_short & ~coll_acc_q;

  assign frame_stat[`RXPF_B_GROUP_SEEN]     = group_q & ~all_ones_q;
  assign frame_stat[`RXPF_B_ALL_ONES_SEEN]  = all_ones_q;
  assign frame_stat[`RXPF_B_FINAL_FRAME]    = final_q;
  assign frame_stat[`RXPF_B_CARRIER_SEEN]   = carr_acc_q;
  assign frame_stat[`RXPF_B_COLLISION_SEEN] = coll_acc_q;
  // checksum fault suppressed for alignment faults and short frames
  assign frame_stat[`RXPF_B_CHECKSUM_FAULT] = crc_q & ~align_q &
                                              ~is_short;
  assign frame_stat[`RXPF_B_ALIGN_FAULT]    = crc_q & align_q;
  assign frame_stat[`RXPF_B_LOOPED_FRAME]   = clean &
                          (loop_sel != `RXPF_LOOP_NONE);
  assign frame_stat[`RXPF_B_CLEAN_FRAME]    = clean;

  // ========================================================================
  // frame state machine
  // ========================================================================
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (rx_start) begin
          state_d = ST_HEAD;
        end
      end
      ST_HEAD: begin
        if (rx_start) begin
          state_d = ST_HEAD;
        end else if (I_RX_FRAME_END) begin
          state_d = ST_END;
        end else if (I_RX_DEST_VALID) begin
          state_d = ST_BODY;
        end
      end
      ST_BODY: begin
        if (rx_start) begin
          state_d = ST_HEAD;
        end else if (I_RX_FRAME_END) begin
          state_d = ST_END;
        end
      end
      ST_END: begin
        if (rx_start) begin
          state_d = ST_HEAD;
        end else begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ========================================================================
  // byte counter, saturating
  // ========================================================================
  always @* begin
    byte_cnt_d = byte_cnt_q;
    if (rx_start) begin
      byte_cnt_d = 11'h000;
    end else if (I_RX_BYTE_STB && (byte_cnt_q != `RXPF_BYTE_CNT_MAX)) begin
      byte_cnt_d = byte_cnt_q + 11'h001;
    end
  end

  // ========================================================================
  // control bits: software writes through the upper lane
  // ========================================================================
  always @* begin
    ctrl_d = ctrl_q;
    if (apb_wr_stb && I_PSTRB[1]) begin
      ctrl_d = I_PWDATA[15:9];
    end
  end

  // ========================================================================
  // status bits: all but carrier and collision cleared at start, loaded at an accepted frame's close
  // ========================================================================
  always @* begin
    stat_d = stat_q;
    if (deciding && frame_ok) begin
      // a close in the same cycle as a start wins over its clear
      stat_d = frame_stat;
    end else if (rx_start) begin
      stat_d = stat_q & ~`RXPF_START_CLEAR_MASK;
    end
  end

  // ========================================================================
  // registers; I_SOFT_RST is deliberately not a term here
  // ========================================================================
  always @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      state_q    <= ST_IDLE;
      ctrl_q     <= `RXPF_CTRL_RESET;
      stat_q     <= `RXPF_STAT_RESET;
      byte_cnt_q <= 11'h000;
    end else begin
      state_q    <= state_d;
      ctrl_q     <= ctrl_d;
      stat_q     <= stat_d;
      byte_cnt_q <= byte_cnt_d;
    end
  end

  // ========================================================================
  // per-frame capture of destination kind and error conditions
  // ========================================================================
  always @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      group_q     <= 1'b0;
      all_ones_q  <= 1'b0;
      unicast_q   <= 1'b0;
      table_q     <= 1'b0;
      dest_seen_q <= 1'b0;
      coll_acc_q  <= 1'b0;
      carr_acc_q  <= 1'b0;
      crc_q       <= 1'b0;
      align_q     <= 1'b0;
      final_q     <= 1'b0;
    end else if (rx_start) begin
      group_q     <= 1'b0;
      all_ones_q  <= 1'b0;
      unicast_q   <= 1'b0;
      table_q     <= 1'b0;
      dest_seen_q <= 1'b0;
      coll_acc_q  <= I_RX_COLLISION;
      carr_acc_q  <= I_RX_CARRIER;
      crc_q       <= 1'b0;
      align_q     <= 1'b0;
      final_q     <= 1'b0;
    end else begin
      if (I_RX_DEST_VALID && (state_q == ST_HEAD)) begin
        group_q     <= dest_group;
        all_ones_q  <= dest_all_ones;
        unicast_q   <= dest_unicast;
        table_q     <= I_RX_TABLE_MATCH;
        dest_seen_q <= 1'b1;
      end
      if (state_q == ST_HEAD || state_q == ST_BODY) begin
        coll_acc_q <= coll_acc_q | I_RX_COLLISION;
        carr_acc_q <= carr_acc_q | I_RX_CARRIER;
      end
      if (I_RX_FRAME_END && (state_q == ST_HEAD || state_q == ST_BODY)) begin
        crc_q   <= I_RX_CHECKSUM_ERR;
        align_q <= I_RX_ALIGN_ERR;
        final_q <= I_RX_FINAL_IN_BUFFER;
      end
    end
  end

  // ========================================================================
  // verdict pulses and descriptor status hand-off
  // ========================================================================
  always @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      accept_q      <= 1'b0;
      reject_q      <= 1'b0;
      desc_valid_q  <= 1'b0;
      desc_status_q <= 16'h0000;
    end else begin
      accept_q <= deciding & frame_ok;
      reject_q <= deciding & ~frame_ok;
      if (deciding && frame_ok) begin
        desc_valid_q  <= 1'b1;
        desc_status_q <= {ctrl_q, frame_stat};
      end else if (I_DESC_ACK) begin
        desc_valid_q  <= 1'b0;
      end
    end
  end

  // ========================================================================
  // apb read data, captured in the setup cycle
  // ========================================================================
  always @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      prdata_q <= 32'h0000_0000;
    end else if (apb_setup) begin
      if (apb_hit && !I_PWRITE) begin
        prdata_q <= {16'h0000, ctrl_q, stat_q};
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // ========================================================================
  // outputs
  // ========================================================================
  assign O_PRDATA       = prdata_q;
  assign O_PREADY       = apb_pready;
  assign O_PSLVERR      = apb_pslverr;
  assign O_LOOP_MODE    = loop_sel;
  assign O_FRAME_ACCEPT = accept_q;
  assign O_FRAME_REJECT = reject_q;
  assign O_DESC_VALID   = desc_valid_q;
  assign O_DESC_STATUS  = desc_status_q;

endmodule

/* File: verif/rxpf_props.sv */
// checker for the receive filter block ports
// assumes: bound to rxpf_top, one clock domain
`timescale 1ns/100ps
module rxpf_props (
  input wire        I_CLOCK,        // clock
  input wire        I_SYS_RST,      // reset
  input wire        I_PSEL,         // select
  input wire        I_PENABLE,      // enable
  input wire        I_PWRITE,       // direction
  input wire [7:0]  I_PADDR,        // address
  input wire [31:0] I_PWDATA,       // write data
  input wire [3:0]  I_PSTRB,        // lanes
  input wire [31:0] O_PRDATA,       // read data
  input wire        O_PREADY,       // ready
  input wire        O_PSLVERR,      // error
  input wire        I_RX_FRAME_END, // frame end
  input wire [1:0]  O_LOOP_MODE,    // loop select
  input wire        O_FRAME_ACCEPT, // kept
  input wire        O_FRAME_REJECT, // dropped
  input wire        O_DESC_VALID,   // pending
  input wire [15:0] O_DESC_STATUS   // descriptor word
);
  // ========================================================================
  // properties
  // ========================================================================
  wire wr = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE &&
            I_PADDR == 8'h08 && I_PSTRB[1];
  wire setup = I_PSEL && !I_PENABLE;
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_SYS_RST);
  rdy_timing_a: assert property (setup |=> O_PREADY)
    else $error("ready missing after setup");
  unmapped_err_a: assert property (setup && I_PADDR != 8'h08
    |=> O_PSLVERR && O_PRDATA == 32'h0000_0000) else $error("no error");
  loop_write_a: assert property (wr
    |=> O_LOOP_MODE == $past(I_PWDATA[10:9])) else $error("loop not set");
  loop_hold_a: assert property (!wr |=> $stable(O_LOOP_MODE))
    else $error("loop changed without write");
  end_decide_a: assert property (I_RX_FRAME_END
    |-> ##1 !(O_FRAME_ACCEPT || O_FRAME_REJECT)
    ##1 (O_FRAME_ACCEPT ^ O_FRAME_REJECT)) else $error("no decision");
  desc_copy_a: assert property (O_FRAME_ACCEPT
    |-> O_DESC_VALID && O_DESC_STATUS[10:9] == O_LOOP_MODE)
    else $error("descriptor not loaded");
  align_only_a: assert property (O_FRAME_ACCEPT
    |-> !(O_DESC_STATUS[3] && O_DESC_STATUS[2])) else $error("both faults");
  clean_bit_a: assert property (O_FRAME_ACCEPT && O_DESC_STATUS[0]
    |-> O_DESC_STATUS[4:2] == 3'h0) else $error("clean with fault");
  looped_ok_a: assert property (O_FRAME_ACCEPT && O_DESC_STATUS[1]
    |-> O_LOOP_MODE != 2'h0 && O_DESC_STATUS[0]) else $error("bad looped");
  cover property (O_FRAME_ACCEPT);
  cover property (O_FRAME_REJECT);
  cover property (O_PSLVERR);
endmodule

/* File: verif/rxpf_net_model.sv */
// network side model: plays one frame onto the receive strobes
// assumes: the bench calls send or start_only, all on i_clock
`timescale 1ns/100ps
module rxpf_net_model (
  input  wire        i_clock, // clock
  output reg         o_start, // frame begins
  output reg         o_dv,    // dest valid
  output reg  [47:0] o_dest,  // dest address
  output reg         o_tm,    // table hit
  output reg         o_bstb,  // byte strobe
  output reg         o_coll,  // collision
  output reg         o_car,   // carrier
  output reg         o_end,   // frame end
  output reg         o_crc,   // bad checksum
  output reg         o_aln,   // odd bit count
  output reg         o_fin    // last in buffer
);
  // ========================================================================
  // frame player, released dest, table, crc, align and final lines show the inverse, carrier and collision drop to 0
  // ========================================================================
  initial {o_start, o_dv, o_dest, o_tm, o_bstb, o_coll, o_car, o_end,
           o_crc, o_aln, o_fin} = '0;
  task send(input [47:0] d, input m, input [7:0] nb, input c, a, o, f);
    begin
      @(posedge i_clock);
      o_start <= 1'b1;
      o_car <= 1'b1;
      o_coll <= o;
      @(posedge i_clock);
      o_start <= 1'b0;
      o_dv <= 1'b1;
      o_dest <= d;
      o_tm <= m;
      @(posedge i_clock);
      o_dv <= 1'b0;
      o_dest <= ~d;
      o_tm <= ~m;
      o_bstb <= 1'b1;
      repeat (nb) @(posedge i_clock);
      o_bstb <= 1'b0;
      o_end <= 1'b1;
      {o_crc, o_aln, o_fin} <= {c, a, f};
      @(posedge i_clock);
      o_end <= 1'b0;
      {o_crc, o_aln, o_fin} <= ~{c, a, f};
      {o_car, o_coll} <= 2'h0;
    end
  endtask
  task start_only;
    begin
      @(posedge i_clock);
      o_start <= 1'b1;
      @(posedge i_clock);
      o_start <= 1'b0;
    end
  endtask
endmodule

/* File: verif/rxpf_top_tb.sv */
// self-checking bench for the receive filter and status register
// assumes: net model drives the receive side, apb master lives here
`timescale 1ns/100ps
module rxpf_top_tb;
  reg         clk = 1'b0, rst = 1'b1, srst = 1'b0, ack = 1'b0, err;
  reg         psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  reg  [7:0]  paddr = 8'h00;
  reg  [3:0]  pstrb = 4'hF;
  reg  [31:0] pwdata = 32'h0000_0000, rd;
  wire [31:0] prdata;
  wire        pready, pslverr, st, dv, tm, bs, co, ca, fe, ce, ae, fi;
  wire        acc, rej, dval;
  wire [1:0]  loop;
  wire [47:0] dst;
  wire [15:0] desc;
  integer     fail_count = 0, n_tests = 0;
  always #2 clk = ~clk;
  rxpf_top DUT (.I_CLOCK(clk), .I_SYS_RST(rst), .I_SOFT_RST(srst),
    .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .I_PSTRB(pstrb), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_RX_FRAME_START(st),
    .I_RX_DEST_VALID(dv), .I_RX_DEST(dst), .I_RX_TABLE_MATCH(tm),
    .I_RX_BYTE_STB(bs), .I_RX_COLLISION(co), .I_RX_CARRIER(ca),
    .I_RX_FRAME_END(fe), .I_RX_CHECKSUM_ERR(ce), .I_RX_ALIGN_ERR(ae),
    .I_RX_FINAL_IN_BUFFER(fi), .I_DESC_ACK(ack), .O_LOOP_MODE(loop),
    .O_FRAME_ACCEPT(acc), .O_FRAME_REJECT(rej), .O_DESC_VALID(dval),
    .O_DESC_STATUS(desc));
  rxpf_net_model NET (.i_clock(clk), .o_start(st), .o_dv(dv), .o_dest(dst),
    .o_tm(tm), .o_bstb(bs), .o_coll(co), .o_car(ca), .o_end(fe),
    .o_crc(ce), .o_aln(ae), .o_fin(fi));
  // ========================================================================
  // bus cycle, compare and scenarios
  // ========================================================================
  task chk(input [31:0] g, e);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d, input [3:0] s);
    begin
      @(posedge clk);
      {psel, pen, pwr, paddr, pwdata, pstrb} <= {2'h2, w, a, d, s};
      @(posedge clk);
      pen <= 1'b1;
      // only the watchdog ends a wait for ready
      do
        @(posedge clk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      {psel, pen} <= 2'h0;
    end
  endtask
  task fr(input [15:0] cfg, input [1:0] k, input m, input [7:0] nb,
          input c, a, o);
    reg [47:0] d;
    reg [8:0]  s;
    reg        sh, ex;
    integer    i;
    begin
      d = k == 0 ? 48'h0200_0000_0001 : k == 1 ? 48'h0100_5E00_0001
                                               : 48'hFFFF_FFFF_FFFF;
      sh = nb < 64;
      ex = (m | cfg[13] & k == 2 | cfg[12] & k == 0 | cfg[11] & k != 0)
           & (!(c | o) | cfg[15]) & (!sh | cfg[14]);
      s = {k == 1, k == 2, nb[0], 1'b1, o, c & !a & !sh, c & a,
           cfg[10:9] != 0 && !c && !sh && !o, !c && !sh && !o};
      apb(1'b1, 8'h08, {16'h0000, cfg}, 4'hF);
      NET.send(d, m, nb, c, a, o, nb[0]);
      i = 0;
      while (acc !== 1'b1 && rej !== 1'b1 && i < 9) begin
        @(posedge clk);
        i = i + 1;
      end
      chk(acc, ex);
      chk(rej, !ex);
      if (ex) begin
        chk(desc, {cfg[15:9], s});
        chk(dval, 1'b1);
        ack <= 1'b1;
        apb(1'b0, 8'h08, 32'h0000_0000, 4'hF);
        ack <= 1'b0;
        chk(rd, {16'h0000, cfg[15:9], s});
        chk(dval, 1'b0);
      end
    end
  endtask
  task t_regs;
    integer j;
    begin
      apb(1'b0, 8'h08, 32'h0000_0000, 4'hF);
      chk(rd, 32'h0000_0000);
      apb(1'b1, 8'h08, 32'hFFFF_FFFF, 4'hF);
      apb(1'b1, 8'h08, 32'h0000_0000, 4'h1);
      srst <= 1'b1;
      apb(1'b0, 8'h08, 32'h0000_0000, 4'hF);
      srst <= 1'b0;
      chk(rd, 32'h0000_FE00);
      apb(1'b0, 8'h10, 32'h0000_0000, 4'hF);
      chk({rd[31:1], err}, 32'h0000_0001);
      for (j = 0; j < 4; j = j + 1) begin
        apb(1'b1, 8'h08, j << 9, 4'hF);
        @(posedge clk);
        chk(loop, j);
      end
    end
  endtask
  task t_frames;
    begin
      fr(16'h0000, 0, 1, 64, 0, 0, 0);
      fr(16'h0000, 0, 0, 64, 0, 0, 0);
      fr(16'h1000, 0, 0, 64, 0, 0, 0);
      fr(16'h1000, 1, 0, 64, 0, 0, 0);
      fr(16'h2000, 2, 0, 64, 0, 0, 0);
      fr(16'h2000, 0, 1, 64, 0, 0, 0);
      fr(16'h0800, 1, 0, 64, 0, 0, 0);
      fr(16'h0800, 2, 0, 64, 0, 0, 0);
      fr(16'h0000, 0, 1, 64, 1, 0, 0);
      fr(16'h0000, 0, 1, 64, 0, 0, 1);
      fr(16'h8000, 0, 1, 64, 1, 0, 0);
      fr(16'h0000, 0, 1, 63, 0, 0, 0);
      fr(16'hC000, 0, 1, 63, 1, 0, 0);
      fr(16'h0200, 0, 1, 64, 0, 0, 0);
    end
  endtask
  task t_clear;
    begin
      fr(16'h8000, 1, 1, 64, 1, 1, 1);
      NET.start_only;
      apb(1'b0, 8'h08, 32'h0000_0000, 4'hF);
      chk(rd, 32'h0000_8030);
    end
  endtask
  task conclude;
    begin
      $display("tests=%0d mismatches=%0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_frames;
    t_clear;
    conclude;
  end
  initial begin
    #100000;
    fail_count = fail_count + 1;
    conclude;
  end
endmodule
bind rxpf_top rxpf_props P (.I_CLOCK, .I_SYS_RST, .I_PSEL, .I_PENABLE,
  .I_PWRITE, .I_PADDR, .I_PWDATA, .I_PSTRB, .O_PRDATA, .O_PREADY,
  .O_PSLVERR, .I_RX_FRAME_END, .O_LOOP_MODE, .O_FRAME_ACCEPT,
  .O_FRAME_REJECT, .O_DESC_VALID, .O_DESC_STATUS);
